// ---- tb/adcc_far_model.sv ----
module adcc_far_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Bench requests
  input  wire logic       trigReq,
  input  wire logic [9:0] nextValue,
  // Converter side
  input  wire logic       samplePhase,
  output logic            hwTriggerIn,
  output logic            alternateClock,
  output logic            internalAsyncClock,
  output logic      [9:0] convValue
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] tick;

  // Sources are slow enough to be sampled as data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick               <= 5'h00;
      alternateClock     <= 1'b0;
      internalAsyncClock <= 1'b0;
    end else begin
      tick               <= (tick == 5'h1D) ? 5'h00 : tick + 5'h01;
      alternateClock     <= (tick % 6) >= 3;
      internalAsyncClock <= (tick % 10) >= 5;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hwTriggerIn <= 1'b0;
      convValue   <= 10'h000;
    end else begin
      hwTriggerIn <= trigReq;
      // Input not settled while it is being sampled
      convValue   <= samplePhase ? ~nextValue : nextValue;
    end
  end
endmodule : adcc_far_model

// ---- tb/testbench.sv ----
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import adcc_pkg::*;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, trigReq;
  logic        hwTriggerIn, alternateClock, internalAsyncClock, converterClock, samplePhase;
  logic [7:0]  paddr, c;
  logic [31:0] pwdata, prdata;
  logic [9:0]  convValue, nv, last, v, cv;
  logic [4:0]  channelSelect;
  logic        ge, hit;
  adcc_cfg_s   cfgOut;
  logic [32:0] expQ[$];
  int          err_total = 0;
  int          compares = 0;
  int          ckPulses = 0;
  int          spCycles = 0;
  int          n0, s0, srcPer;
  logic [32:0] expHead;

  adcc_adc_control dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hwTriggerIn(hwTriggerIn), .alternateClock(alternateClock),
    .internalAsyncClock(internalAsyncClock), .convValue(convValue),
    .converterClock(converterClock), .samplePhase(samplePhase),
    .channelSelect(channelSelect), .cfgOut(cfgOut));

  adcc_far_model far (.mclk(mclk), .rst_n(rst_n), .trigReq(trigReq), .nextValue(nv),
    .samplePhase(samplePhase), .hwTriggerIn(hwTriggerIn), .alternateClock(alternateClock),
    .internalAsyncClock(internalAsyncClock), .convValue(convValue));

  // ----------------------------------------------------------------
  // Read monitor: oldest note against each completed read
  // ----------------------------------------------------------------
  // Head is popped once so a mismatch cannot shift the queue
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expQ.size() == 0) begin
        err_total++;
        $display("[FAIL] %0t read with no note", $time);
      end else begin
        expHead = expQ.pop_front();
        `CHK({pslverr, prdata}, expHead)
      end
    end
  end

  // Converter clock pulses and sampling cycles, counted per edge
  always @(posedge mclk) begin
    if (converterClock === 1'b1) ckPulses <= ckPulses + 1;
    if (samplePhase === 1'b1) spCycles <= spCycles + 1;
  end

  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Note is queued before the access so the monitor never races it
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    @(posedge mclk);
    if (!w) expQ.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("[FAIL] %0t bus hang", $time);
      report_and_stop();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e});
  endtask : rd

  task automatic conv(input logic [9:0] val, input logic upd, input int cyc = 60);
    nv <= val;
    wr(OFS_SC1, 8'h03);
    repeat (cyc) @(posedge mclk);
    if (upd) last = val;
  endtask : conv

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    trigReq = 1'b0;
    nv      = 10'h000;
    last    = 10'h000;
    void'($urandom(31389));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_CFG, CFG_RESET);
    rd(OFS_SC2, 8'h00);
    rd(OFS_SC1, {3'h0, CHAN_RESET});
    rd(OFS_CVL, CV_RESET);
    apb(1'b0, 8'h40, 8'h00, {1'b1, 32'h0});
    // Every source and divide code; slowest case needs ~2300 cycles
    for (int i = 0; i < 4; i++) begin
      c = {i[0], i[1:0], i[1], MODE_8BIT, i[1:0]};
      wr(OFS_CFG, c);
      rd(OFS_CFG, c);
      `CHK(cfgOut, c)
      v  = 10'($urandom_range(1023));
      s0 = spCycles;
      conv(v, 1'b1, 2600);
      rd(OFS_RL, v[7:0]);
      // Bus clock undivided: one sampling cycle per sample tick
      if (i == 0) `CHK(spCycles - s0, SHORT_SAMPLE_TICKS)
      // Far model source periods: bus 1, halved 2, alternate 6, internal 10
      srcPer = (i == 0) ? 1 : (i == 1) ? 2 : (i == 2) ? 6 : 10;
      n0     = ckPulses;
      repeat (240) @(posedge mclk);
      `CHK(ckPulses - n0, 240 / (srcPer << i))
    end
    wr(OFS_CFG, 8'h00);
    wr(OFS_SC1, 8'h03);
    rd(OFS_SC2, 8'h80);
    `CHK(channelSelect, 5'h03)
    wr(OFS_SC1, 8'h1F);
    rd(OFS_SC2, 8'h00);
    rd(OFS_SC1, 8'h1F);
    v = 10'($urandom_range(1023));
    conv(v, 1'b1);
    rd(OFS_SC1, 8'h83);
    rd(OFS_SC2, 8'h00);
    rd(OFS_RH, 8'h00);
    rd(OFS_RL, v[7:0]);
    rd(OFS_SC1, 8'h03);
    rd(OFS_RH, 8'h00);
    v = 10'($urandom_range(1023));
    conv(v, 1'b1);
    rd(OFS_RL, v[7:0]);
    wr(OFS_CFG, {4'h0, MODE_10BIT, CLK_BUS});
    v = 10'($urandom_range(1023));
    conv(v, 1'b1);
    rd(OFS_RH, {6'h00, v[9:8]});
    conv(~v, 1'b0);
    rd(OFS_RH, {6'h00, v[9:8]});
    rd(OFS_RL, v[7:0]);
    v = 10'($urandom_range(1023));
    conv(v, 1'b1);
    rd(OFS_RH, {6'h00, v[9:8]});
    rd(OFS_RL, v[7:0]);
    // Both polarities, condition true and false
    for (int k = 0; k < 4; k++) begin
      ge  = k[0];
      hit = k[1];
      cv  = 10'($urandom_range(1022, 1));
      v   = (ge == hit) ? 10'($urandom_range(1023, cv)) : 10'($urandom_range(cv - 1, 0));
      wr(OFS_CVH, {6'h00, cv[9:8]});
      wr(OFS_CVL, cv[7:0]);
      wr(OFS_SC2, {2'b00, 1'b1, ge, 4'h0});
      conv(v, hit);
      rd(OFS_SC1, {hit, 7'h03});
      rd(OFS_RH, {6'h00, last[9:8]});
      rd(OFS_RL, last[7:0]);
    end
    wr(OFS_CFG, 8'h00);
    wr(OFS_CVH, 8'h03);
    wr(OFS_CVL, 8'h80);
    wr(OFS_SC2, 8'h30);
    conv(10'h0C0, 1'b1);
    rd(OFS_RL, 8'hC0);
    rd(OFS_CVH, 8'h03);
    wr(OFS_SC2, 8'h10);
    conv(10'h010, 1'b1);
    rd(OFS_RL, 8'h10);
    wr(OFS_SC2, 8'h40);
    wr(OFS_SC1, 8'h03);
    rd(OFS_SC2, 8'h40);
    v = 10'($urandom_range(1023));
    nv      <= v;
    trigReq <= 1'b1;
    repeat (3) @(posedge mclk);
    trigReq <= 1'b0;
    rd(OFS_SC2, 8'hC0);
    repeat (60) @(posedge mclk);
    rd(OFS_RL, v[7:0]);
    wr(OFS_SC2, 8'h00);
    trigReq <= 1'b1;
    repeat (3) @(posedge mclk);
    trigReq <= 1'b0;
    rd(OFS_SC2, 8'h00);
    report_and_stop();
  end
endmodule : testbench

// ---- verilog/adcc_adc_control.sv ----
// Operation
// - Active flag sets when a conversion starts, clears on completion or abort.
// - Trigger select: 0 starts on control-one write, 1 on hardware trigger.
// - Compare enable bit turns the automatic compare on or off.
// - Polarity 0 means result below value, 1 means result at or above.
// - Result high holds bits 9:8; reads zero in 8-bit mode (after leaving 10-bit, old bits 9:8 stay until an 8-bit result transfers).
// - Results update on completion unless compare enabled and condition false.
// - In 10-bit mode reading result high locks results until result low read.
// - Conversions finishing while locked are discarded.
// - In 8-bit mode reads never create the lock.
// - Compare high supplies upper bits in 10-bit mode, ignored in 8-bit.
// - Compare low is checked against lower eight result bits in both modes.
// - Configuration bit 7 picks high speed or low power setting.
// - Divide field gives ratios 1, 2, 4, 8 of the input clock.
// - Configuration bit 4 picks short or long sample time.
// - Resolution code 00 is 8-bit, 10 is 10-bit; others reserved.
// - Clock source: bus, bus halved, alternate, internal asynchronous.
// - Control-one write aborts; with trigger select 0 starts new conversion unless channel all ones.
// - Done flag sets on completion with compare off or on true compare; clears on control-one write or low read.
//
// Our own choices: the register addresses and register access over APB.
module adcc_adc_control
  import adcc_pkg::*;
#(
  parameter int SHORT_TICKS = SHORT_SAMPLE_TICKS,
  parameter int LONG_TICKS  = LONG_SAMPLE_TICKS
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Trigger and clock sources
  input  wire logic              hwTriggerIn,
  input  wire logic              alternateClock,
  input  wire logic              internalAsyncClock,
  // Analog core
  input  wire logic [9:0]        convValue,
  output logic                   converterClock,
  output logic                   samplePhase,
  output logic      [4:0]        channelSelect,
  output adcc_cfg_s              cfgOut
);
  import adcc_pkg::*;

  if (SHORT_TICKS < 1 || LONG_TICKS < SHORT_TICKS || LONG_TICKS > 32) begin : gTickRange
    $error("sample tick counts out of range");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  adcc_sc2_s   sc2;
  adcc_cfg_s   cfg;
  adcc_state_e state;
  logic [7:0]  cmpHigh;
  logic [7:0]  cmpLow;
  logic [7:0]  resultHigh;
  logic [7:0]  resultLow;
  logic        doneFlag;
  logic        interlock;
  logic        hwTrigPrev;
  logic        altPrev;
  logic        asyncPrev;
  logic        halfToggle;
  logic [2:0]  divCnt;
  logic [4:0]  tickCnt;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic apbDone;
  logic wrEn;
  logic rdEn;
  logic sc1Write;
  logic cfgWrite;
  logic rhRead;
  logic rlRead;
  logic tenBit;

  assign apbDone  = psel && penable && pready;
  assign wrEn     = apbDone && pwrite;
  assign rdEn     = apbDone && !pwrite;
  assign sc1Write = wrEn && (paddr == OFS_SC1);
  assign cfgWrite = wrEn && (paddr == OFS_CFG);
  assign rhRead   = rdEn && (paddr == OFS_RH);
  assign rlRead   = rdEn && (paddr == OFS_RL);
  assign tenBit   = (cfg.mode == MODE_10BIT);

  // One wait state: pready rises at the first access edge, the transfer ends at the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  logic [7:0] readMux;
  logic       addrBad;

  always_comb begin
    readMux = 8'h00;
    addrBad = 1'b0;
    case (paddr)
      OFS_SC1: readMux = {doneFlag, 2'b00, channelSelect};
      OFS_SC2: readMux = {state != ST_IDLE, sc2.hwTrig, sc2.cmpEn, sc2.cmpGe, 4'h0};
      OFS_RH:  readMux = resultHigh;
      OFS_RL:  readMux = resultLow;
      OFS_CVH: readMux = cmpHigh;
      OFS_CVL: readMux = cmpLow;
      OFS_CFG: readMux = cfg;
      default: addrBad = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= {24'h00_0000, readMux};
      pslverr <= addrBad;
    end else begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channelSelect <= CHAN_RESET;
      sc2           <= '0;
      cfg           <= CFG_RESET;
      cmpHigh       <= CV_RESET;
      cmpLow        <= CV_RESET;
    end else if (wrEn) begin
      case (paddr)
        OFS_SC1: channelSelect <= pwdata[4:0];
        // Reserved low bits are not stored
        OFS_SC2: sc2 <= {pwdata[SC2_TRIG_BIT], pwdata[SC2_CMPEN_BIT],
                         pwdata[SC2_CMPGE_BIT]};
        OFS_CVH: cmpHigh <= {6'h00, pwdata[1:0]};
        OFS_CVL: cmpLow <= pwdata[7:0];
        OFS_CFG: cfg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  assign cfgOut = cfg;

  // ----------------------------------------------------------------
  // Converter clock: source select then divide
  // ----------------------------------------------------------------
  logic       srcTick;
  logic       convTick;
  logic [2:0] divLast;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halfToggle <= 1'b0;
      altPrev    <= 1'b0;
      asyncPrev  <= 1'b0;
      hwTrigPrev <= 1'b0;
    end else begin
      halfToggle <= !halfToggle;
      altPrev    <= alternateClock;
      asyncPrev  <= internalAsyncClock;
      hwTrigPrev <= hwTriggerIn;
    end
  end

  // Outside clocks count on their rising edges; they must run below mclk/2
  always_comb begin
    srcTick = 1'b0;
    case (cfg.clkSel)
      CLK_BUS:      srcTick = 1'b1;
      CLK_BUS_HALF: srcTick = halfToggle;
      CLK_ALT:      srcTick = alternateClock && !altPrev;
      CLK_ASYNC:    srcTick = internalAsyncClock && !asyncPrev;
      default:      srcTick = 1'b0;
    endcase
  end

  assign divLast  = 3'((4'h1 << cfg.clkDiv) - 4'h1);
  assign convTick = srcTick && (divCnt == divLast);

  // Restart the divider on a config write so a shrinking ratio never overshoots
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= 3'h0;
    end else if (cfgWrite || convTick) begin
      divCnt <= 3'h0;
    end else if (srcTick) begin
      divCnt <= divCnt + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      converterClock <= 1'b0;
    end else begin
      converterClock <= convTick;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  logic       hwEdge;
  logic       startReq;
  logic       convDone;
  logic [4:0] sampleLast;
  logic [4:0] bitsLast;

  assign hwEdge   = hwTriggerIn && !hwTrigPrev;
  assign startReq = (sc1Write && !sc2.hwTrig && pwdata[4:0] != CHAN_OFF) ||
                    (!sc1Write && sc2.hwTrig && hwEdge && channelSelect != CHAN_OFF);
  assign sampleLast = cfg.longSample ? 5'(LONG_TICKS - 1) : 5'(SHORT_TICKS - 1);
  assign bitsLast   = tenBit ? 5'(BITS_10 - 1) : 5'(BITS_8 - 1);
  assign convDone   = (state == ST_CONVERT) && convTick && (tickCnt == bitsLast) && !sc1Write;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      tickCnt     <= 5'h00;
      samplePhase <= 1'b0;
    end else if (startReq) begin
      state       <= ST_SAMPLE;
      tickCnt     <= 5'h00;
      samplePhase <= 1'b1;
    end else if (sc1Write) begin
      state       <= ST_IDLE;
      tickCnt     <= 5'h00;
      samplePhase <= 1'b0;
    end else if (convTick) begin
      unique case (state)
        ST_IDLE: begin
          tickCnt <= 5'h00;
        end
        ST_SAMPLE: begin
          if (tickCnt == sampleLast) begin
            state       <= ST_CONVERT;
            tickCnt     <= 5'h00;
            samplePhase <= 1'b0;
          end else begin
            tickCnt <= tickCnt + 5'h01;
          end
        end
        ST_CONVERT: begin
          if (tickCnt == bitsLast) begin
            state   <= ST_IDLE;
            tickCnt <= 5'h00;
          end else begin
            tickCnt <= tickCnt + 5'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Compare and result transfer
  // ----------------------------------------------------------------
  logic [9:0] resultNew;
  logic [9:0] cmpValue;
  logic       cmpLess;
  logic       cmpTrue;
  logic       keepResult;
  logic       blocked;

  assign resultNew  = tenBit ? convValue : {2'b00, convValue[7:0]};
  // Upper compare bits only take part in 10-bit mode
  assign cmpValue   = tenBit ? {cmpHigh[1:0], cmpLow} : {2'b00, cmpLow};
  assign cmpLess    = resultNew < cmpValue;
  assign cmpTrue    = sc2.cmpGe ? !cmpLess : cmpLess;
  assign keepResult = !sc2.cmpEn || cmpTrue;
  assign blocked    = interlock && !rlRead;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resultHigh <= 8'h00;
      resultLow  <= 8'h00;
    end else if (convDone && keepResult && !blocked) begin
      resultHigh <= {6'h00, resultNew[9:8]};
      resultLow  <= resultNew[7:0];
    end
  end

  // Lock only exists in 10-bit mode; leaving it drops any lock held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interlock <= 1'b0;
    end else if (!tenBit || rlRead) begin
      interlock <= 1'b0;
    end else if (rhRead) begin
      interlock <= 1'b1;
    end
  end

  // Setting wins over a same-cycle low read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      doneFlag <= 1'b0;
    end else if (convDone && keepResult) begin
      doneFlag <= 1'b1;
    end else if (sc1Write || rlRead) begin
      doneFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence lockTaken;
    rhRead && tenBit ##1 interlock;
  endsequence

  sequence lockedDone;
    interlock && !rlRead && convDone;
  endsequence

  active_set_a: assert property (startReq |=> state == ST_SAMPLE && samplePhase)
    else $error("conversion did not start");
  active_clear_a: assert property (convDone && !startReq |=> state == ST_IDLE)
    else $error("active flag not cleared at completion");
  sw_trig_a: assert property (sc1Write && sc2.hwTrig && !$past(startReq) |=>
                              state == ST_IDLE)
    else $error("software write started a conversion in hardware trigger mode");
  abort_a: assert property (sc1Write && pwdata[4:0] == CHAN_OFF |=>
                            state == ST_IDLE && !doneFlag)
    else $error("disable write did not abort");
  cmp_hold_a: assert property (convDone && sc2.cmpEn && !cmpTrue |=>
                               $stable(resultLow) && $stable(resultHigh) && !$rose(doneFlag))
    else $error("false compare changed results");
  high_zero_a: assert property (convDone && !tenBit && keepResult |=>
                                resultHigh == 8'h00)
    else $error("result high nonzero in 8-bit mode");
  lock_set_a: assert property (lockTaken |-> interlock throughout (!rlRead [*2]))
    else $error("interlock dropped without low read");
  lock_drop_a: assert property (lockedDone |=> $stable(resultLow))
    else $error("result transferred while locked");
  no_lock8_a: assert property (rhRead && !tenBit |=> !interlock)
    else $error("interlock set in 8-bit mode");
  cmp_ten_a: assert property (convDone && tenBit && sc2.cmpEn && !blocked &&
                              (sc2.cmpGe == (convValue >= {cmpHigh[1:0], cmpLow})) |=>
                              {resultHigh[1:0], resultLow} == $past(convValue))
    else $error("10-bit compare mismatch");
  done_clr_a: assert property (rlRead && !convDone |=> !doneFlag)
    else $error("done flag not cleared by low read");

endmodule : adcc_adc_control

// ---- verilog/adcc_pkg.sv ----
package adcc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W  = 8;
  localparam logic [7:0]  OFS_SC1 = 8'h00;
  localparam logic [7:0]  OFS_SC2 = 8'h04;
  localparam logic [7:0]  OFS_RH  = 8'h08;
  localparam logic [7:0]  OFS_RL  = 8'h0C;
  localparam logic [7:0]  OFS_CVH = 8'h10;
  localparam logic [7:0]  OFS_CVL = 8'h14;
  localparam logic [7:0]  OFS_CFG = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int          SC1_DONE_BIT   = 7;
  localparam int          SC2_ACTIVE_BIT = 7;
  localparam int          SC2_TRIG_BIT   = 6;
  localparam int          SC2_CMPEN_BIT  = 5;
  localparam int          SC2_CMPGE_BIT  = 4;
  localparam logic [4:0]  CHAN_OFF       = 5'h1F;
  localparam logic [1:0]  MODE_8BIT      = 2'h0;
  localparam logic [1:0]  MODE_10BIT     = 2'h2;
  localparam logic [1:0]  CLK_BUS        = 2'h0;
  localparam logic [1:0]  CLK_BUS_HALF   = 2'h1;
  localparam logic [1:0]  CLK_ALT        = 2'h2;
  localparam logic [1:0]  CLK_ASYNC      = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [4:0]  CHAN_RESET = 5'h1F;
  localparam logic [7:0]  CV_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Converter clock counts
  // ----------------------------------------------------------------
  localparam int          SHORT_SAMPLE_TICKS = 4;
  localparam int          LONG_SAMPLE_TICKS  = 20;
  localparam int          BITS_10            = 10;
  localparam int          BITS_8             = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       lowPower;
    logic [1:0] clkDiv;
    logic       longSample;
    logic [1:0] mode;
    logic [1:0] clkSel;
  } adcc_cfg_s;

  typedef struct packed {
    logic hwTrig;
    logic cmpEn;
    logic cmpGe;
  } adcc_sc2_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } adcc_state_e;

endpackage : adcc_pkg
